/* hw/static_mem_consts.svh */
// Constants of the static memory controller front end.
`ifndef STATIC_MEM_CONSTS_SVH
`define STATIC_MEM_CONSTS_SVH
`define SMC_NUM_CS 6
`define SMC_ADDR_W 26
`define SMC_DATA_W 32
`define SMC_TIME_W 6
`define SMC_PAGE_MIN_BYTES 4
`define SMC_PAGE_MAX_BYTES 32
`define SMC_SLOW_SETUP 6'h00
`define SMC_SLOW_PULSE 6'h01
`define SMC_SLOW_CYCLE 6'h01
`define SMC_RESET_WIDTH 2'h0
`define SMC_RESET_LANE 1'h0
`define SMC_FLOAT_W 4
`endif

/* hw/static_mem_pkg.sv */
// Types of the static memory controller front end.
package static_mem_pkg;
  typedef enum logic [1:0] {
    bus_w8 = 2'h0,
    bus_w16 = 2'h1,
    bus_w32 = 2'h2
  } bus_width_sel_e;
  typedef enum logic {
    lane_sel_mode = 1'h0,
    lane_write_mode = 1'h1
  } lane_access_type_e;
  typedef enum logic [1:0] {
    size_byte = 2'h0,
    size_half = 2'h1,
    size_word = 2'h2
  } xfer_size_e;
endpackage

/* hw/static_mem_timing_if.sv */
// Interface carrying strobe timing between controller and phase counter.
`timescale 1ns/1ns
`default_nettype none
`include "static_mem_consts.svh"
interface static_mem_timing_if;
  logic start;
  logic is_write;
  logic [`SMC_TIME_W-1:0] strobe_setup;
  logic [`SMC_TIME_W-1:0] strobe_pulse;
  logic [`SMC_TIME_W-1:0] cs_setup;
  logic [`SMC_TIME_W-1:0] cs_pulse;
  logic [`SMC_TIME_W-1:0] cycle_len;
  logic hold_off;
  logic strobe_on;
  logic cs_on;
  logic strobe_end;
  logic cycle_done;
  logic busy;
  modport ctrl (
    output start, is_write, strobe_setup, strobe_pulse, cs_setup, cs_pulse, cycle_len,
    output hold_off,
    input strobe_on, cs_on, strobe_end, cycle_done, busy
  );
  modport phase (
    input start, is_write, strobe_setup, strobe_pulse, cs_setup, cs_pulse, cycle_len,
    input hold_off,
    output strobe_on, cs_on, strobe_end, cycle_done, busy
  );
endinterface
`default_nettype wire

/* hw/static_mem_phase.sv */
// Cycle counter producing strobe and chip select phases of one access.
`timescale 1ns/1ns
`default_nettype none
`include "static_mem_consts.svh"
module static_mem_phase (
  input wire logic clock_i,
  input wire logic rst_i,
  static_mem_timing_if.phase tif
);
  logic [`SMC_TIME_W-1:0] count;
  logic running;

  // Hold is what remains of the cycle after setup and pulse.
  assign tif.strobe_on = running && (count >= tif.strobe_setup) &&
    (count < tif.strobe_setup + tif.strobe_pulse);
  assign tif.cs_on = running && (count >= tif.cs_setup) &&
    (count < tif.cs_setup + tif.cs_pulse);
  assign tif.strobe_end = running && (count == tif.strobe_setup + tif.strobe_pulse - 1'b1);
  assign tif.cycle_done = running && !tif.hold_off && (count + 1'b1 >= tif.cycle_len);
  assign tif.busy = running;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      running <= 1'b0;
      count <= '0;
    end else if (!running) begin
      running <= tif.start;
      count <= '0;
    end else if (tif.hold_off) begin
      count <= count;
    end else if (tif.cycle_done) begin
      running <= 1'b0;
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* hw/static_mem_byte_lane_ctrl.sv */
// Static memory controller front end: chip selects, address, lane pins and data bus.
`timescale 1ns/1ns
`default_nettype none
`include "static_mem_consts.svh"
module static_mem_byte_lane_ctrl
  import static_mem_pkg::*;
#(
  parameter int NUM_CS = `SMC_NUM_CS,
  parameter int ADDR_W = `SMC_ADDR_W,
  parameter int TIME_W = `SMC_TIME_W,
  parameter int FLOAT_W = `SMC_FLOAT_W
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [2:0] req_cs_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [1:0] req_size_i,
  input wire logic [31:0] req_wdata_i,
  input wire logic [2:0] req_burst_len_i,
  input wire logic req_boot_i,
  input wire logic slow_clock_i,
  input wire logic [NUM_CS*2-1:0] bus_width_sel_i,
  input wire logic [NUM_CS-1:0] lane_access_type_i,
  input wire logic [NUM_CS*TIME_W-1:0] read_setup_i,
  input wire logic [NUM_CS*TIME_W-1:0] read_pulse_i,
  input wire logic [NUM_CS*TIME_W-1:0] read_cycle_len_i,
  input wire logic [NUM_CS*TIME_W-1:0] write_setup_i,
  input wire logic [NUM_CS*TIME_W-1:0] write_pulse_i,
  input wire logic [NUM_CS*TIME_W-1:0] write_cycle_len_i,
  input wire logic [NUM_CS*TIME_W-1:0] cs_setup_i,
  input wire logic [NUM_CS*TIME_W-1:0] cs_pulse_i,
  input wire logic [NUM_CS*FLOAT_W-1:0] data_float_i,
  input wire logic ext_wait_n_i,
  input wire logic [31:0] data_in_i,
  output logic req_ready_o,
  output logic resp_valid_o,
  output logic resp_error_o,
  output logic [31:0] resp_rdata_o,
  output logic [NUM_CS-1:0] chip_sel_n_o,
  output logic read_strobe_n_o,
  output logic [ADDR_W-1:2] addr_hi_o,
  output logic pin0_o,
  output logic pin1_o,
  output logic pin2_o,
  output logic pin3_o,
  output logic [31:0] data_out_o,
  output logic data_oe_o
);
  // -----------------------------------------------------------------
  // Helper functions
  // -----------------------------------------------------------------
  function automatic logic [3:0] lane_mask(input logic [1:0] width, input logic [1:0] size,
                                           input logic [1:0] low);
    logic [3:0] m;
    m = 4'h0;
    unique case (size)
      size_byte: m = 4'h1;
      size_half: m = 4'h3;
      default: m = 4'hF;
    endcase
    if (width == bus_w16) begin
      m = (size == size_byte) ? (low[0] ? 4'h2 : 4'h1) : 4'h3;
    end else if (width == bus_w32) begin
      m = 4'((m << (size == size_word ? 2'h0 : (size == size_half ? {low[1], 1'b0} : low))));
    end else begin
      m = 4'h1;
    end
    return m;
  endfunction

  function automatic logic [TIME_W-1:0] pick(input logic [NUM_CS*TIME_W-1:0] v,
                                             input logic [2:0] cs);
    return v[cs*TIME_W +: TIME_W];
  endfunction

  // -----------------------------------------------------------------
  // Access state
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {st_idle, st_access, st_float} state_e;
  state_e state;
  static_mem_timing_if tif();
  logic [2:0] cur_cs;
  logic cur_write;
  logic [1:0] cur_width;
  logic cur_lane_write;
  logic [ADDR_W-1:0] cur_addr;
  logic [1:0] cur_size;
  logic [31:0] cur_wdata;
  logic [3:0] cur_mask;
  logic [2:0] beats_left;
  logic [FLOAT_W-1:0] float_count;
  logic cur_slow;
  logic accept;
  logic refuse;
  logic wait_req;
  logic [ADDR_W-1:0] next_addr;

  assign wait_req = !ext_wait_n_i;
  // Boot through a write-strobe select on a 16- or 32-bit bus cannot work: read data path exists, but loaders
  // rely on lane-select wiring, so the request is answered with an error.
  assign refuse = req_boot_i &&
    (lane_access_type_i[req_cs_i] == lane_write_mode) &&
    (bus_width_sel_i[req_cs_i*2 +: 2] != bus_w8);
  // Ready is high while idle, except the first idle cycle after reset, so a request is only ever taken with ready seen high.
  assign accept = req_ready_o && req_valid_i && (req_cs_i < 3'(NUM_CS)) && !refuse;

  // Page bursts advance by one bus width per beat; the width fixes the step.
  assign next_addr = cur_addr + ADDR_W'(cur_width == bus_w32 ? 4 :
    (cur_width == bus_w16 ? 2 : 1));

  assign tif.start = (state == st_access) && !tif.busy;
  assign tif.is_write = cur_write;
  assign tif.hold_off = wait_req && tif.busy;
  // Slow clock mode overrides every timing the select was programmed with except its float time.
  assign tif.strobe_setup = cur_slow ? `SMC_SLOW_SETUP :
    (cur_write ? pick(write_setup_i, cur_cs) : pick(read_setup_i, cur_cs));
  assign tif.strobe_pulse = cur_slow ? `SMC_SLOW_PULSE :
    (cur_write ? pick(write_pulse_i, cur_cs) : pick(read_pulse_i, cur_cs));
  assign tif.cs_setup = cur_slow ? `SMC_SLOW_SETUP : pick(cs_setup_i, cur_cs);
  assign tif.cs_pulse = cur_slow ? `SMC_SLOW_CYCLE : pick(cs_pulse_i, cur_cs);
  assign tif.cycle_len = cur_slow ? `SMC_SLOW_CYCLE :
    (cur_write ? pick(write_cycle_len_i, cur_cs) : pick(read_cycle_len_i, cur_cs));

  static_mem_phase u_phase (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tif(tif)
  );

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= st_idle;
      cur_cs <= 3'h0;
      cur_write <= 1'b0;
      cur_width <= `SMC_RESET_WIDTH;
      cur_lane_write <= `SMC_RESET_LANE;
      cur_addr <= '0;
      cur_size <= 2'h0;
      cur_wdata <= 32'h0;
      cur_mask <= 4'h0;
      beats_left <= 3'h0;
      float_count <= '0;
      cur_slow <= 1'b0;
    end else begin
      unique case (state)
        st_idle: begin
          if (accept) begin
            state <= st_access;
            cur_cs <= req_cs_i;
            cur_write <= req_write_i;
            cur_width <= bus_width_sel_i[req_cs_i*2 +: 2];
            cur_lane_write <= lane_access_type_i[req_cs_i];
            cur_addr <= req_addr_i;
            cur_size <= req_size_i;
            cur_wdata <= req_wdata_i;
            cur_mask <= lane_mask(bus_width_sel_i[req_cs_i*2 +: 2], req_size_i,
                                  req_addr_i[1:0]);
            beats_left <= req_write_i ? 3'h0 : req_burst_len_i;
            cur_slow <= slow_clock_i;
          end
        end
        st_access: begin
          if (tif.cycle_done) begin
            if (beats_left != 3'h0) begin
              beats_left <= beats_left - 3'h1;
              cur_addr <= next_addr;
            end else begin
              state <= st_float;
              float_count <= data_float_i[cur_cs*FLOAT_W +: FLOAT_W];
            end
          end
        end
        st_float: begin
          // Float time keeps the next access off the bus while the device releases it.
          if (float_count == '0) begin
            state <= st_idle;
          end else begin
            float_count <= float_count - 1'b1;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Request handshake and read data
  // -----------------------------------------------------------------
  logic resp_due;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      req_ready_o <= 1'b0;
      resp_due <= 1'b0;
      resp_valid_o <= 1'b0;
      resp_error_o <= 1'b0;
      resp_rdata_o <= 32'h0;
    end else begin
      req_ready_o <= ((state == st_idle) && !accept) ||
        ((state == st_float) && (float_count == '0));
      // The strobe pin is registered, so data is taken one edge after the internal
      // pulse ends: the edge that raises the pin, which also works for one-cycle pulses.
      resp_due <= (state == st_access) && tif.strobe_end && !tif.hold_off;
      resp_valid_o <= 1'b0;
      resp_error_o <= 1'b0;
      if (req_ready_o && req_valid_i && (refuse || req_cs_i >= 3'(NUM_CS))) begin
        resp_valid_o <= 1'b1;
        resp_error_o <= 1'b1;
      end else if (resp_due) begin
        resp_valid_o <= 1'b1;
        resp_rdata_o <= data_in_i;
      end
    end
  end

  // -----------------------------------------------------------------
  // Pin multiplexing
  // -----------------------------------------------------------------
  logic [3:0] lane_on;
  logic wr_on;
  logic rd_on;
  assign wr_on = (state == st_access) && cur_write && tif.strobe_on;
  assign rd_on = (state == st_access) && !cur_write && tif.strobe_on;
  // Lane selects follow the address timing, so they span the whole access.
  assign lane_on = (state == st_access) ? cur_mask : 4'h0;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      chip_sel_n_o <= '1;
      read_strobe_n_o <= 1'b1;
      addr_hi_o <= '0;
      pin0_o <= 1'b1;
      pin1_o <= 1'b1;
      pin2_o <= 1'b1;
      pin3_o <= 1'b1;
    end else begin
      chip_sel_n_o <= '1;
      if (state == st_access && tif.cs_on) begin
        chip_sel_n_o[cur_cs] <= 1'b0;
      end
      read_strobe_n_o <= !rd_on;
      addr_hi_o <= cur_addr[ADDR_W-1:2];
      if (cur_width == bus_w8) begin
        pin0_o <= cur_addr[0];
        pin1_o <= !wr_on;
        pin2_o <= cur_addr[1];
        pin3_o <= 1'b1;
      end else if (cur_lane_write == lane_write_mode) begin
        // pin0 is idle here; pin1, pin3 and, on a 32-bit bus, pin2 are write strobes for lanes 0, 1 and 2.
        pin0_o <= 1'b1;
        pin1_o <= !(wr_on && lane_on[0]);
        pin2_o <= (cur_width == bus_w16) ? cur_addr[1] : !(wr_on && lane_on[2]);
        pin3_o <= (cur_width == bus_w16) ? !(wr_on && lane_on[1]) :
          !(wr_on && lane_on[1]);
      end else begin
        pin0_o <= !lane_on[0];
        pin1_o <= !wr_on;
        pin2_o <= (cur_width == bus_w16) ? cur_addr[1] : !lane_on[2];
        pin3_o <= !lane_on[1];
      end
    end
  end

  // -----------------------------------------------------------------
  // Data bus drive
  // -----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      data_out_o <= 32'h0;
      data_oe_o <= 1'b0;
    end else begin
      data_out_o <= cur_wdata;
      // Drive from the end of setup to the end of the cycle, as write devices need.
      data_oe_o <= (state == st_access) && cur_write && tif.busy &&
        (tif.strobe_on || (data_oe_o && !tif.cycle_done));
    end
  end
endmodule
`default_nettype wire

/* tb/static_mem_checker.sv */
// Port assertions for the static memory front end.
`timescale 1ns/1ns
`default_nettype none
module static_mem_checker #(
  parameter int NUM_CS = 6
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic [2:0] req_cs_i,
  input wire logic req_boot_i,
  input wire logic [NUM_CS*2-1:0] bus_width_sel_i,
  input wire logic [NUM_CS-1:0] lane_access_type_i,
  input wire logic ext_wait_n_i,
  input wire logic req_ready_o,
  input wire logic resp_valid_o,
  input wire logic resp_error_o,
  input wire logic [NUM_CS-1:0] chip_sel_n_o,
  input wire logic read_strobe_n_o,
  input wire logic pin0_o,
  input wire logic pin1_o,
  input wire logic pin3_o,
  input wire logic data_oe_o
);
  logic take;
  logic cur_w8;
  logic cur_ws;
  assign take = req_valid_i && req_ready_o;
  // Mode of the select in use, kept because the inputs may change mid access.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cur_w8 <= 1'b1;
      cur_ws <= 1'b0;
    end else if (take && req_cs_i < NUM_CS) begin
      cur_w8 <= bus_width_sel_i[req_cs_i*2+:2] == 2'h0;
      cur_ws <= lane_access_type_i[req_cs_i];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence wait_held;
    !ext_wait_n_i [*2];
  endsequence
  sequence refused_now;
    take && (req_cs_i >= NUM_CS || req_boot_i && lane_access_type_i[req_cs_i]
      && bus_width_sel_i[req_cs_i*2+:2] != 2'h0);
  endsequence
  one_select_a: assert property ($countones(~chip_sel_n_o) <= 1)
    else $error("two selects low");
  boot_refused_a: assert property (refused_now |=> resp_valid_o && resp_error_o)
    else $error("refusal missing");
  error_pulse_a: assert property (resp_error_o |-> resp_valid_o)
    else $error("error without response");
  answer_bound_a: assert property (take |-> ##[1:200] resp_valid_o)
    else $error("no response");
  strobe_excl_a: assert property (!read_strobe_n_o |-> pin1_o && !data_oe_o)
    else $error("read overlaps write");
  wait_stretch_a: assert property (wait_held ##0 !read_strobe_n_o |=> !read_strobe_n_o)
    else $error("wait ignored");
  ws_lane_idle_a: assert property (!cur_w8 && cur_ws && !(&chip_sel_n_o) |-> pin0_o)
    else $error("lane select in strobe mode");
  narrow_pin3_a: assert property (cur_w8 && !(&chip_sel_n_o) |-> pin3_o)
    else $error("pin3 active on narrow bus");
  reset_idle_a: assert property (disable iff (1'b0) rst_i |=> &chip_sel_n_o
    && read_strobe_n_o && pin0_o && pin1_o && pin3_o && !data_oe_o)
    else $error("outputs active in reset");
endmodule
bind static_mem_byte_lane_ctrl static_mem_checker #(.NUM_CS(NUM_CS)) i_static_mem_checker (
  .clock_i, .rst_i, .req_valid_i, .req_cs_i, .req_boot_i, .bus_width_sel_i,
  .lane_access_type_i, .ext_wait_n_i, .req_ready_o, .resp_valid_o, .resp_error_o,
  .chip_sel_n_o, .read_strobe_n_o, .pin0_o, .pin1_o, .pin3_o, .data_oe_o);
`default_nettype wire

/* tb/static_mem_partner.sv */
// Behavioural external memory on the far side of the controller.
`timescale 1ns/1ns
`default_nettype none
module static_mem_partner (
  input wire logic clock_i,
  input wire logic [5:0] chip_sel_n_i,
  input wire logic read_strobe_n_i,
  input wire logic [7:0] addr_i,
  input wire logic pin0_i,
  input wire logic pin1_i,
  input wire logic pin2_i,
  input wire logic pin3_i,
  input wire logic [31:0] data_i,
  input wire logic data_oe_i,
  input wire logic lane_sel_mode_i,
  input wire logic stall_i,
  output logic [31:0] data_o,
  output logic wait_n_o
);
  logic [31:0] mem [256];
  logic [31:0] last;
  logic [3:0] en;
  int stall_left = 0;
  // A released bus shows the inverse of the last word, so a late sample is caught.
  assign data_o = !read_strobe_n_i ? mem[addr_i] : ~last;
  assign en = {~pin2_i, ~pin2_i, ~pin3_i, lane_sel_mode_i ? ~pin0_i : ~pin1_i};
  assign wait_n_o = stall_left == 0;
  always @(posedge clock_i) begin
    if (!read_strobe_n_i) last <= mem[addr_i];
    if (data_oe_i && (!lane_sel_mode_i || !pin1_i) && chip_sel_n_i != 6'h3F) begin
      for (int i = 0; i < 4; i++) if (en[i]) mem[addr_i][i*8+:8] <= data_i[i*8+:8];
    end
    if ($fell(read_strobe_n_i) && stall_i) stall_left <= 3;
    else if (stall_left > 0) stall_left <= stall_left - 1;
  end
endmodule
`default_nettype wire

/* tb/static_mem_byte_lane_ctrl_tb.sv */
// Self-checking bench for the static memory front end.
`timescale 1ns/1ns
`default_nettype none
module static_mem_byte_lane_ctrl_tb;
  import static_mem_pkg::*;
  logic clock_i = 0, rst_i = 1, req_valid_i = 0, req_write_i = 0, req_boot_i = 0;
  logic slow_clock_i = 0, ext_wait_n_i, part_lane = 1, stall = 0;
  logic [2:0] req_cs_i = 0, req_burst_len_i = 0;
  logic [25:0] req_addr_i = 0;
  logic [1:0] req_size_i = 0;
  logic [31:0] req_wdata_i = 0, data_in_i, resp_rdata_o, data_out_o;
  logic [11:0] bus_width_sel_i = 0;
  logic [5:0] lane_access_type_i = 0, chip_sel_n_o;
  // Slow enough that a wait lands inside the strobe pulse.
  logic [35:0] read_setup_i = {6{6'h01}}, read_pulse_i = {6{6'h04}};
  logic [35:0] read_cycle_len_i = {6{6'h08}}, write_setup_i = {6{6'h01}};
  logic [35:0] write_pulse_i = {6{6'h04}}, write_cycle_len_i = {6{6'h08}};
  logic [35:0] cs_setup_i = {6{6'h00}}, cs_pulse_i = {6{6'h08}};
  logic [23:0] data_float_i = {6{4'h1}};
  logic req_ready_o, resp_valid_o, resp_error_o, read_strobe_n_o, data_oe_o;
  logic pin0_o, pin1_o, pin2_o, pin3_o;
  logic [25:2] addr_hi_o;
  int fails = 0, compares = 0, seed = 30915;
  logic [31:0] ref_mem [int];
  static_mem_byte_lane_ctrl i_static_mem_byte_lane_ctrl (.clock_i, .rst_i, .req_valid_i,
    .req_write_i, .req_cs_i, .req_addr_i, .req_size_i, .req_wdata_i, .req_burst_len_i,
    .req_boot_i, .slow_clock_i, .bus_width_sel_i, .lane_access_type_i, .read_setup_i,
    .read_pulse_i, .read_cycle_len_i, .write_setup_i, .write_pulse_i, .write_cycle_len_i,
    .cs_setup_i, .cs_pulse_i, .data_float_i, .ext_wait_n_i, .data_in_i, .req_ready_o,
    .resp_valid_o, .resp_error_o, .resp_rdata_o, .chip_sel_n_o, .read_strobe_n_o,
    .addr_hi_o, .pin0_o, .pin1_o, .pin2_o, .pin3_o, .data_out_o, .data_oe_o);
  static_mem_partner i_static_mem_partner (.clock_i, .chip_sel_n_i(chip_sel_n_o),
    .read_strobe_n_i(read_strobe_n_o), .addr_i(addr_hi_o[9:2]), .pin0_i(pin0_o),
    .pin1_i(pin1_o), .pin2_i(pin2_o), .pin3_i(pin3_o), .data_i(data_out_o),
    .data_oe_i(data_oe_o), .lane_sel_mode_i(part_lane), .stall_i(stall),
    .data_o(data_in_i), .wait_n_o(ext_wait_n_i));
  always #5 clock_i = ~clock_i;
  task automatic tally_and_finish();
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [3:0] lanes(logic [1:0] w, logic [1:0] lo, logic [1:0] sz);
    if (sz == 2) return 4'hF;
    if (w == 1) return sz == 1 ? 4'h3 : 4'h1 << lo[0];
    return sz == 1 ? 4'h3 << {lo[1], 1'b0} : 4'h1 << lo;
  endfunction
  task automatic shuffle_modes();
    for (int c = 0; c < 6; c++) begin
      bus_width_sel_i[c*2+:2] = 2'(($random(seed) & 32'h7FFF) % 3);
      lane_access_type_i[c] = 1'($random(seed));
    end
  endtask
  // ------------------------------------------------------------
  // One access: drive, watch the pins while selected, judge the answer.
  // ------------------------------------------------------------
  task automatic access(input logic [2:0] cs, input logic wr, input logic [25:0] a,
      input logic [1:0] sz, input logic boot, output int dur);
    logic [1:0] w;
    logic lt;
    logic [3:0] m, seen;
    logic [31:0] wd;
    int n;
    w = cs < 6 ? bus_width_sel_i[cs*2+:2] : 2'h0;
    lt = cs < 6 ? lane_access_type_i[cs] : 1'b0;
    m = lanes(w, a[1:0], sz);
    seen = 4'h0;
    wd = $random(seed);
    dur = 0;
    n = 0;
    // One idle edge between requests, so valid never rises in the step where it fell.
    @(negedge clock_i);
    part_lane = !lt;
    {req_cs_i, req_write_i, req_addr_i, req_size_i, req_boot_i} = {cs, wr, a, sz, boot};
    req_wdata_i = wd;
    req_valid_i = 1;
    while (req_ready_o !== 1'b1 && n < 50) begin
      @(negedge clock_i);
      n++;
    end
    @(negedge clock_i);
    req_valid_i = 0;
    n = 0;
    while (resp_valid_o !== 1'b1 && n < 200) begin
      if (chip_sel_n_o !== 6'h3F) begin
        dur++;
        check("select", ~(32'h1 << cs) & 32'h3F, chip_sel_n_o);
        check("address", a[25:2], addr_hi_o);
        if (w == 0) check("narrow", {1'b1, a[1:0]}, {pin3_o, pin2_o, pin0_o});
        else if (!lt) check("lanes", {~m[1], w == 2 ? ~m[2] : a[1], ~m[0]},
          {pin3_o, pin2_o, pin0_o});
        else begin
          check("idle sel", {1'b1, w == 2 ? pin2_o : a[1]}, {pin0_o, pin2_o});
          seen = seen | {1'b0, ~pin2_o & w == 2, ~pin3_o, ~pin1_o};
        end
      end
      @(negedge clock_i);
      n++;
    end
    check("resp", 1, resp_valid_o);
    check("error", cs > 5 || boot && lt && w != 0, resp_error_o);
    if (lt && w != 0 && cs < 6 && !boot) check("strobes", wr ? m & 4'h7 : 0, seen);
    if (cs < 6 && !boot && w == 2 && sz == 2) begin
      if (wr) ref_mem[a[9:2]] = wd;
      else if (ref_mem.exists(a[9:2])) check("rdata", ref_mem[a[9:2]], resp_rdata_o);
    end else if (wr) ref_mem.delete(a[9:2]);
  endtask
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
  initial begin
    int dur, base, c;
    logic [1:0] w, sz;
    logic [25:0] a;
    shuffle_modes();
    repeat (2) @(negedge clock_i);
    check("reset", 12'hFFE, {chip_sel_n_o, read_strobe_n_o, pin3_o, pin2_o,
      pin1_o, pin0_o, data_oe_o});
    rst_i = 0;
    bus_width_sel_i[11:8] = 4'h9;
    lane_access_type_i[5:4] = 2'b10;
    bus_width_sel_i[1:0] = 2'h2;
    lane_access_type_i[0] = 1'b0;
    access(5, 0, 0, 0, 1, dur);
    access(4, 0, 0, 0, 1, dur);
    access(6, 0, 0, 0, 0, dur);
    access(0, 1, 26'h4, 2, 0, dur);
    access(0, 0, 26'h4, 2, 0, base);
    stall = 1;
    access(0, 0, 26'h4, 2, 0, dur);
    stall = 0;
    check("stretch", base + 3, dur);
    access(0, 1, 26'h8, 2, 0, dur);
    req_burst_len_i = 3'h1;
    access(0, 0, 26'h4, 2, 0, dur);
    c = 0;
    @(negedge clock_i);
    while (resp_valid_o !== 1'b1 && c < 50) begin
      @(negedge clock_i);
      c++;
    end
    req_burst_len_i = 3'h0;
    check("beat data", ref_mem[2], resp_rdata_o);
    check("beat addr", 32'h2, addr_hi_o);
    for (int i = 0; i < 60; i++) begin
      if (i % 15 == 0) shuffle_modes();
      c = ($random(seed) & 32'h7FFF) % 6;
      w = bus_width_sel_i[c*2+:2];
      sz = 2'(($random(seed) & 32'h7FFF) % (w + 1));
      a = {16'($random(seed)), 5'h0, 3'($random(seed)),
        2'($random(seed)) & (sz == 0 ? 2'h3 : sz == 1 ? 2'h2 : 2'h0)};
      slow_clock_i = i % 20 == 19;
      access(3'(c), 1'($random(seed)), a, sz, 0, dur);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
